// *** shared/rmc_pkg.sv ***
// Constants shared by the mode and collision register bank
package rmc_pkg;
  // Register offsets on the host register port
  localparam logic [5:0] ADDR_COLLISION_REPORT = 6'h0e;
  localparam logic [5:0] ADDR_RESERVED_SLOT_A = 6'h0f;
  localparam logic [5:0] ADDR_RESERVED_SLOT_B = 6'h10;
  localparam logic [5:0] ADDR_GENERAL_COMM_MODE = 6'h11;
  localparam logic [5:0] ADDR_TRANSMIT_MODE = 6'h12;

  // Reset values
  localparam logic [7:0] RST_GENERAL_COMM_MODE = 8'h3f;
  localparam logic [7:0] RST_TRANSMIT_MODE = 8'h00;
  localparam logic [7:0] RST_RESERVED = 8'h00;
  localparam logic RST_KEEP_BITS = 1'b1;

  // Collision report fields
  localparam int COLL_KEEP_BIT = 7;
  localparam int COLL_INVALID_BIT = 5;
  localparam int COLL_POS_LSB = 0;
  localparam logic [5:0] COLL_POS_LIMIT = 6'h20;
  localparam logic [5:0] COLL_CNT_MAX = 6'h3f;

  // General mode fields; bits 6, 4 and 2 are reserved
  localparam int MODE_CRC_ORDER_BIT = 7;
  localparam int MODE_WAIT_FIELD_BIT = 5;
  localparam int MODE_ENV_POL_BIT = 3;
  localparam int MODE_PRESET_LSB = 0;
  localparam logic [7:0] MODE_WRITE_MASK = 8'ha3 | 8'h08;
  localparam logic [7:0] MODE_READ_MASK = 8'hbf;

  // Transmit mode fields; bit 2 is reserved
  localparam int TXM_CRC_EN_BIT = 7;
  localparam int TXM_RATE_LSB = 4;
  localparam int TXM_INV_BIT = 3;
  localparam int TXM_FRAMING_LSB = 0;
  localparam logic [7:0] TXM_WRITE_MASK = 8'hfb;

  // Bit rate codes; codes from 3'h4 upward are reserved
  localparam logic [2:0] RATE_106 = 3'h0;
  localparam logic [2:0] RATE_212 = 3'h1;
  localparam logic [2:0] RATE_424 = 3'h2;
  localparam logic [2:0] RATE_848 = 3'h3;

  // Framing codes
  typedef enum logic [1:0] {
    RMC_FRAME_A = 2'b00,
    RMC_FRAME_RSVD1 = 2'b01,
    RMC_FRAME_RSVD2 = 2'b10,
    RMC_FRAME_B = 2'b11
  } rmc_framing_t;

  // CRC preset values selected by the 2-bit preset field
  localparam logic [15:0] CRC_PRESET_0 = 16'h0000;
  localparam logic [15:0] CRC_PRESET_1 = 16'h6363;
  localparam logic [15:0] CRC_PRESET_2 = 16'ha671;
  localparam logic [15:0] CRC_PRESET_3 = 16'hffff;
endpackage

// *** design/rmc_coll_track.sv ***
// First-collision tracker for received frames
`timescale 1ns/1ps
`default_nettype none
module rmc_coll_track import rmc_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic rx_frame_start,
  input wire logic rx_data_bit,
  input wire logic rx_bit_collision,
  input wire logic keep_bits_after_collision,
  output logic [4:0] collision_position,
  output logic collision_position_invalid,
  output logic rx_drop_bits
);
  logic [5:0] bit_count;
  logic found;
  logic [5:0] next_count;

  // Data bit index of the bit now arriving, saturating so long frames never wrap
  always_comb begin
    next_count = (bit_count == COLL_CNT_MAX) ? bit_count : 6'(bit_count + 6'h01);
  end

  // Count data bits only; a new frame restarts everything
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bit_count <= 6'h00;
    end else if (rx_frame_start) begin
      bit_count <= 6'h00;
    end else if (rx_data_bit) begin
      bit_count <= next_count;
    end
  end

  // Capture the first collision; bit 32 wraps to code 0
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      found <= 1'b0;
      collision_position <= 5'h00;
      collision_position_invalid <= 1'b1;
    end else if (rx_frame_start) begin
      found <= 1'b0;
      collision_position <= 5'h00;
      collision_position_invalid <= 1'b1;
    end else if (rx_data_bit && rx_bit_collision && !found) begin
      found <= 1'b1;
      if (next_count <= COLL_POS_LIMIT) begin
        collision_position <= next_count[4:0];
        collision_position_invalid <= 1'b0;
      end else begin
        collision_position_invalid <= 1'b1;
      end
    end
  end

  // Bits after a collision are discarded unless software asks to keep them
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rx_drop_bits <= 1'b0;
    end else if (rx_frame_start) begin
      rx_drop_bits <= 1'b0;
    end else if (rx_data_bit && rx_bit_collision && !found) begin
      rx_drop_bits <= !keep_bits_after_collision;
    end
  end
endmodule // rmc_coll_track
`default_nettype wire

// *** design/rmc_crc_cfg.sv ***
// CRC coprocessor preset selection and result bit ordering
`timescale 1ns/1ps
`default_nettype none
module rmc_crc_cfg import rmc_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic rf_active,
  input wire logic tx_active,
  input wire logic crc_bit_order,
  input wire logic [1:0] crc_preset_select,
  input wire logic [1:0] transmit_framing,
  input wire logic [1:0] receive_framing,
  input wire logic [15:0] crc_result_raw,
  output logic crc_msb_first,
  output logic [15:0] crc_preset_value,
  output logic [15:0] crc_result
);
  logic order_eff;
  logic [1:0] frame_eff;
  logic [15:0] next_preset;
  logic [15:0] raw_rev;

  // Bit order only applies to the standalone command, never on the air
  assign order_eff = crc_bit_order && !rf_active;

  // On the air the preset follows the framing of the current direction
  always_comb begin
    frame_eff = tx_active ? transmit_framing : receive_framing;
    if (rf_active) begin
      next_preset = (frame_eff == RMC_FRAME_B) ? CRC_PRESET_3 : CRC_PRESET_1;
    end else begin
      case (crc_preset_select)
        2'b00: next_preset = CRC_PRESET_0;
        2'b01: next_preset = CRC_PRESET_1;
        2'b10: next_preset = CRC_PRESET_2;
        2'b11: next_preset = CRC_PRESET_3;
        default: next_preset = CRC_PRESET_0;
      endcase
    end
  end

  // Reverse each result byte in place
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      raw_rev[i] = crc_result_raw[7 - i];
      raw_rev[8 + i] = crc_result_raw[15 - i];
    end
  end

  // Registered so the coprocessor sees stable settings
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      crc_msb_first <= 1'b0;
      crc_preset_value <= CRC_PRESET_3;
      crc_result <= 16'h0000;
    end else begin
      crc_msb_first <= order_eff;
      crc_preset_value <= next_preset;
      crc_result <= order_eff ? raw_rev : crc_result_raw;
    end
  end
endmodule // rmc_crc_cfg
`default_nettype wire

// *** design/rmc_regs.sv ***
// Mode, transmit and collision register bank of the contactless core
//
// How it works
// - Collision position counts data bits; code 0 means bit 32, others the bit.
// - Invalid flag is set when no collision or position is beyond 32.
// - With keep-bits off, received bits after a collision are dropped.
// - Bit order 1 makes CRC MSB first with both result bytes reversed.
// - Bit order control is ignored while RF communication runs.
// - With wait-for-field set, transmit starts only while the field is on.
// - Envelope pin is active high for polarity 1, active low for 0.
// - Internal envelope is active low; polarity change raises an activity event.
// - Standalone CRC preset: 0000, 6363, a671 or ffff from two bits.
// - During RF traffic the preset follows framing, not the select field.
// - Transmit CRC enable appends a generated CRC to sent data.
// - Three-bit transmit rate: 106, 212, 424, 848; upper codes reserved.
// - Modulation inversion inverts the modulation of sent data.
// - Transmit framing: 00 type A, 11 type B, others reserved.
// - Reserved registers at 0f and 10 exist, reset to 00.
`timescale 1ns/1ps
`default_nettype none
module rmc_regs import rmc_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_b,
  // Host register port
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rdata_valid,
  // Receiver side
  input wire logic rx_frame_start,
  input wire logic rx_data_bit,
  input wire logic rx_bit_collision,
  input wire logic [1:0] receive_framing,
  output logic rx_drop_bits,
  // Transmitter and RF state
  input wire logic rf_active,
  input wire logic tx_active,
  input wire logic rf_field_on,
  input wire logic tx_start_req,
  output logic tx_start,
  output logic tx_start_blocked,
  output logic transmit_crc_enable,
  output logic [2:0] transmit_bit_rate,
  output logic transmit_rate_reserved,
  output logic modulation_inversion,
  output logic [1:0] transmit_framing,
  output logic transmit_framing_reserved,
  // Envelope input
  input wire logic envelope_input_pin,
  output logic envelope_internal_n,
  output logic envelope_input_activity_event,
  // CRC coprocessor
  input wire logic [15:0] crc_result_raw,
  output logic crc_msb_first,
  output logic [15:0] crc_preset_value,
  output logic [15:0] crc_result
);
  logic keep_bits_after_collision;
  logic [7:0] general_comm_mode;
  logic [7:0] transmit_mode;
  logic [4:0] collision_position;
  logic collision_position_invalid;
  logic wr_coll;
  logic wr_mode;
  logic wr_txm;
  logic pol_now;
  logic pol_prev;
  logic [7:0] next_rdata;
  logic next_env_n;
  logic crc_bit_order;
  logic wait_for_field;
  logic [1:0] crc_preset_select;
  logic [2:0] rate_field;
  logic [1:0] framing_field;

  // Write strobes per register; unmapped and reserved addresses decode to nothing
  // A read in the cycle of a write to the same register returns the old value
  assign wr_coll = reg_wr && (reg_addr == ADDR_COLLISION_REPORT);
  assign wr_mode = reg_wr && (reg_addr == ADDR_GENERAL_COMM_MODE);
  assign wr_txm = reg_wr && (reg_addr == ADDR_TRANSMIT_MODE);

  // Only the keep-bits control of the collision report is writable
  // Reset keeps bits, the setting wanted outside bitwise anticollision
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      keep_bits_after_collision <= RST_KEEP_BITS;
    end else if (wr_coll) begin
      keep_bits_after_collision <= reg_wdata[COLL_KEEP_BIT];
    end
  end

  // General mode; reserved bits hold their reset value so reads match reset
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      general_comm_mode <= RST_GENERAL_COMM_MODE;
    end else if (wr_mode) begin
      general_comm_mode <= (reg_wdata & MODE_WRITE_MASK) | (general_comm_mode & ~MODE_WRITE_MASK);
    end
  end

  // Transmit mode; reserved bit 2 is never stored
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      transmit_mode <= RST_TRANSMIT_MODE;
    end else if (wr_txm) begin
      transmit_mode <= reg_wdata & TXM_WRITE_MASK;
    end
  end

  // Named fields of the two mode registers
  assign crc_bit_order = general_comm_mode[MODE_CRC_ORDER_BIT];
  assign wait_for_field = general_comm_mode[MODE_WAIT_FIELD_BIT];
  assign crc_preset_select = general_comm_mode[MODE_PRESET_LSB +: 2];
  assign rate_field = transmit_mode[TXM_RATE_LSB +: 3];
  assign framing_field = transmit_mode[TXM_FRAMING_LSB +: 2];

  // CRC generation on send, stored as written
  // Keeping it set above the lowest rate is left to software
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      transmit_crc_enable <= 1'b0;
    end else begin
      transmit_crc_enable <= transmit_mode[TXM_CRC_EN_BIT];
    end
  end

  // Bit rate code for the transmitter
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      transmit_bit_rate <= RATE_106;
    end else begin
      transmit_bit_rate <= rate_field;
    end
  end

  // Reserved rate codes are kept, not rejected,
  // and flagged so the transmitter can refuse them
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      transmit_rate_reserved <= 1'b0;
    end else begin
      transmit_rate_reserved <= rate_field > RATE_848;
    end
  end

  // Modulation inversion
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      modulation_inversion <= 1'b0;
    end else begin
      modulation_inversion <= transmit_mode[TXM_INV_BIT];
    end
  end

  // Framing type for sending
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      transmit_framing <= RMC_FRAME_A;
    end else begin
      transmit_framing <= framing_field;
    end
  end

  // The two codes between type A and type B
  // are reserved and only flagged
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      transmit_framing_reserved <= 1'b0;
    end else begin
      transmit_framing_reserved <= (framing_field == RMC_FRAME_RSVD1) || (framing_field == RMC_FRAME_RSVD2);
    end
  end

  // Start passes when the field is up or gating is off
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tx_start <= 1'b0;
    end else begin
      tx_start <= tx_start_req && (!wait_for_field || rf_field_on);
    end
  end

  // A refused request is reported once and dropped, not held,
  // so a stale start never fires when the field comes up late
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tx_start_blocked <= 1'b0;
    end else begin
      tx_start_blocked <= tx_start_req && wait_for_field && !rf_field_on;
    end
  end

  // Envelope: pin polarity converted to an internal active-low level
  assign pol_now = general_comm_mode[MODE_ENV_POL_BIT];

  // Active-high pin is inverted, active-low pin passes through
  always_comb begin
    next_env_n = envelope_input_pin;
    if (pol_now) begin
      next_env_n = !envelope_input_pin;
    end
  end

  // Registered so the internal level is clean
  // while polarity is being rewritten
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      envelope_internal_n <= 1'b1;
    end else begin
      envelope_internal_n <= next_env_n;
    end
  end

  // Reset matches the register, so no false event follows reset
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pol_prev <= RST_GENERAL_COMM_MODE[MODE_ENV_POL_BIT];
    end else begin
      pol_prev <= pol_now;
    end
  end

  // Any change of polarity looks like envelope activity, so flag it once
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      envelope_input_activity_event <= 1'b0;
    end else begin
      envelope_input_activity_event <= pol_prev != pol_now;
    end
  end

  // Read mux; reserved registers and bits read zero, unmapped too, except general mode bits 4 and 2, which read as stored
  always_comb begin
    next_rdata = 8'h00;
    case (reg_addr)
      ADDR_COLLISION_REPORT: begin
        next_rdata[COLL_KEEP_BIT] = keep_bits_after_collision;
        next_rdata[COLL_INVALID_BIT] = collision_position_invalid;
        next_rdata[COLL_POS_LSB +: 5] = collision_position;
      end
      ADDR_RESERVED_SLOT_A: next_rdata = RST_RESERVED;
      ADDR_RESERVED_SLOT_B: next_rdata = RST_RESERVED;
      ADDR_GENERAL_COMM_MODE: next_rdata = general_comm_mode;
      ADDR_TRANSMIT_MODE: next_rdata = transmit_mode;
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data is registered one cycle after the read strobe
  // and held until the next read
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // Valid marks the one cycle in which a fresh answer stands
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_valid <= 1'b0;
    end else begin
      reg_rdata_valid <= reg_rd;
    end
  end

  // Collision tracking
  rmc_coll_track u_coll (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .rx_frame_start(rx_frame_start),
    .rx_data_bit(rx_data_bit),
    .rx_bit_collision(rx_bit_collision),
    .keep_bits_after_collision(keep_bits_after_collision),
    .collision_position(collision_position),
    .collision_position_invalid(collision_position_invalid),
    .rx_drop_bits(rx_drop_bits)
  );

  // CRC preset and bit ordering
  rmc_crc_cfg u_crc (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .rf_active(rf_active),
    .tx_active(tx_active),
    .crc_bit_order(crc_bit_order),
    .crc_preset_select(crc_preset_select),
    .transmit_framing(framing_field),
    .receive_framing(receive_framing),
    .crc_result_raw(crc_result_raw),
    .crc_msb_first(crc_msb_first),
    .crc_preset_value(crc_preset_value),
    .crc_result(crc_result)
  );
endmodule // rmc_regs
`default_nettype wire

// *** dv/rmc_card_model.sv ***
// Card model that returns received frames to the reader core
`timescale 1ns/1ps
`default_nettype none
module rmc_card_model (
  input wire logic clk_sys,
  output logic rx_frame_start,
  output logic rx_data_bit,
  output logic rx_bit_collision
);
  // Quiet line at start-up
  initial begin
    rx_frame_start = 1'b0;
    rx_data_bit = 1'b0;
    rx_bit_collision = 1'b0;
  end
  // One frame of nbits data bits, collision at bit coll (0 for none), gap idle cycles per bit
  task automatic send_frame(input int nbits, input int coll, input int gap);
    @(negedge clk_sys);
    rx_frame_start = 1'b1;
    @(negedge clk_sys);
    rx_frame_start = 1'b0;
    for (int i = 1; i <= nbits; i++) begin
      rx_data_bit = 1'b1;
      rx_bit_collision = (i == coll);
      @(negedge clk_sys);
      if (gap > 0) begin
        rx_data_bit = 1'b0;
        rx_bit_collision = ~rx_bit_collision; // Unqualified flag shows junk, not the last value
        repeat (gap) @(negedge clk_sys);
      end
    end
    rx_data_bit = 1'b0;
    rx_bit_collision = ~rx_bit_collision;
  endtask
endmodule // rmc_card_model
`default_nettype wire

// *** dv/rmc_regs_checker.sv ***
// Port checker for the mode and collision register bank
`timescale 1ns/1ps
`default_nettype none
module rmc_regs_checker (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic rx_frame_start,
  input wire logic rx_data_bit,
  input wire logic rx_bit_collision,
  input wire logic rx_drop_bits,
  input wire logic rf_active,
  input wire logic rf_field_on,
  input wire logic tx_start_req,
  input wire logic tx_start_blocked,
  input wire logic transmit_crc_enable,
  input wire logic [2:0] transmit_bit_rate,
  input wire logic modulation_inversion,
  input wire logic [1:0] transmit_framing,
  input wire logic envelope_input_pin,
  input wire logic envelope_internal_n,
  input wire logic envelope_input_activity_event,
  input wire logic crc_msb_first,
  input wire logic [15:0] crc_preset_value
);
  localparam logic [15:0] PV [4] = '{16'h0000, 16'h6363, 16'ha671, 16'hffff};
  logic [7:0] mode_sh;
  logic keep_sh;
  logic mode_wr;
  logic txm_wr;
  logic msb_eff;
  logic [15:0] pv_now;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Decoded strobes and expected derived values
  assign mode_wr = reg_wr && reg_addr == 6'h11;
  assign txm_wr = reg_wr && reg_addr == 6'h12;
  assign msb_eff = mode_sh[7] && !rf_active;
  assign pv_now = PV[mode_sh[1:0]];
  // Own copy of the controls, so a stuck design register cannot hide itself
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_sh <= 8'h3f;
      keep_sh <= 1'b1;
    end else begin
      if (mode_wr) begin
        mode_sh <= reg_wdata;
      end
      if (reg_wr && reg_addr == 6'h0e) begin
        keep_sh <= reg_wdata[7];
      end
    end
  end
  property p_wait_field;
    tx_start_req && mode_sh[5] && !rf_field_on |=> tx_start_blocked;
  endproperty
  a_wait_field: assert property (p_wait_field) else $error("start not refused without field");
  property p_pol_event;
    mode_wr && reg_wdata[3] != mode_sh[3] |-> ##2 envelope_input_activity_event;
  endproperty
  a_pol_event: assert property (p_pol_event) else $error("no event on polarity change");
  property p_env_level;
    !mode_wr |=> envelope_internal_n == ($past(envelope_input_pin) ^ mode_sh[3]);
  endproperty
  a_env_level: assert property (p_env_level) else $error("envelope level wrong");
  property p_tx_fields;
    txm_wr ##1 !txm_wr |=> {transmit_crc_enable, transmit_bit_rate, modulation_inversion, 1'b0,
      transmit_framing} == ($past(reg_wdata, 2) & 8'hfb);
  endproperty
  a_tx_fields: assert property (p_tx_fields) else $error("transmit fields wrong");
  property p_read_zero;
    reg_rd && (reg_addr inside {6'h0f, 6'h10} || reg_addr < 6'h0e || reg_addr > 6'h12) |=> reg_rdata == 8'h00;
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("reserved read not zero");
  property p_preset;
    !rf_active |=> crc_preset_value == $past(pv_now);
  endproperty
  a_preset: assert property (p_preset) else $error("standalone preset wrong");
  property p_bit_order;
    1'b1 |=> crc_msb_first == $past(msb_eff);
  endproperty
  a_bit_order: assert property (p_bit_order) else $error("bit order wrong");
  property p_drop;
    rx_data_bit && rx_bit_collision && !rx_frame_start && !keep_sh |=> rx_drop_bits;
  endproperty
  a_drop: assert property (p_drop) else $error("bits not dropped after collision");
  c_blocked: cover property (tx_start_blocked);
  c_event: cover property (envelope_input_activity_event);
  c_drop: cover property (rx_drop_bits);
endmodule // rmc_regs_checker
bind rmc_regs rmc_regs_checker chk_u (.*);
`default_nettype wire

// *** dv/rmc_regs_bench.sv ***
// Self-checking bench for the mode and collision register bank
`timescale 1ns/1ps
`default_nettype none
module rmc_regs_bench;
  logic clk_sys, rst_b, reg_wr, reg_rd, rf_active, tx_active, rf_field_on, tx_start_req;
  logic envelope_input_pin, rx_frame_start, rx_data_bit, rx_bit_collision, reg_rdata_valid;
  logic rx_drop_bits, tx_start, tx_start_blocked, transmit_crc_enable, transmit_rate_reserved;
  logic modulation_inversion, transmit_framing_reserved, envelope_internal_n;
  logic envelope_input_activity_event, crc_msb_first;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [1:0] receive_framing, transmit_framing;
  logic [2:0] transmit_bit_rate;
  logic [15:0] crc_result_raw, crc_preset_value, crc_result;
  int errors, tests_run;
  rmc_regs dut_u (.*);
  rmc_card_model card_u (.*);
  // 10 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Host write, strobe up for one sampling edge
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  // Host read, answer awaited under a bound so a dead port cannot hang the run
  task automatic rdc(input logic [5:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hff);
    int n;
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    n = 0;
    while (reg_rdata_valid !== 1'b1) begin
      n++;
      if (n > 4) begin
        chk(1'b0, 1'b1, "read answer missing");
        report_and_stop();
      end
      @(negedge clk_sys);
    end
    chk(reg_rdata & m, exp, "register read");
  endtask
  // Reset values, reserved slots, unmapped address, write masks
  task automatic t_map();
    rdc(6'h0e, 8'ha0);
    rdc(6'h0f, 8'h00);
    rdc(6'h10, 8'h00);
    rdc(6'h11, 8'h3f);
    rdc(6'h12, 8'h00);
    for (int i = 14; i < 19; i++) begin
      wr(6'(i), 8'hff);
    end
    wr(6'h3f, 8'hff);
    rdc(6'h3f, 8'h00);
    rdc(6'h0f, 8'h00);
    rdc(6'h10, 8'h00);
    rdc(6'h11, 8'hbf);
    rdc(6'h12, 8'hfb);
    rdc(6'h0e, 8'ha0);
    wr(6'h11, 8'h00);
    rdc(6'h11, 8'h14);
    wr(6'h11, 8'h3f);
    wr(6'h12, 8'h00);
  endtask
  // First collision, bit 32 wrap, overflow, dropping of later bits
  task automatic t_collision();
    card_u.send_frame(8, 3, 0);
    rdc(6'h0e, 8'h83);
    card_u.send_frame(6, 0, 2);
    rdc(6'h0e, 8'ha0);
    card_u.send_frame(34, 32, 0);
    rdc(6'h0e, 8'h80);
    card_u.send_frame(36, 33, 1);
    rdc(6'h0e, 8'ha0, 8'he0);
    wr(6'h0e, 8'h00);
    card_u.send_frame(5, 2, 0);
    chk(rx_drop_bits, 1'b1, "bits kept after collision");
    rdc(6'h0e, 8'h02);
    card_u.send_frame(0, 0, 0);
    chk(rx_drop_bits, 1'b0, "drop outlived frame");
    wr(6'h0e, 8'h80);
  endtask
  // One start request with the field at the given level
  task automatic txq(input logic field, input logic go);
    @(negedge clk_sys);
    rf_field_on = field;
    tx_start_req = 1'b1;
    @(negedge clk_sys);
    tx_start_req = 1'b0;
    chk(tx_start, go, "tx start");
    chk(tx_start_blocked, !go, "tx refused");
  endtask
  // Transmit gating, then every rate and framing code, reserved ones too
  task automatic t_tx();
    logic [2:0] r;
    txq(1'b0, 1'b0);
    txq(1'b1, 1'b1);
    wr(6'h11, 8'h0b);
    txq(1'b0, 1'b1);
    wr(6'h11, 8'h3f);
    for (int i = 0; i < 8; i++) begin
      r = 3'(i);
      wr(6'h12, {r != 3'h0, r, r[0], 1'b0, r[1:0]});
      @(negedge clk_sys);
      chk({transmit_crc_enable, transmit_bit_rate, modulation_inversion}, {r != 3'h0, r, r[0]}, "mode");
      chk({transmit_rate_reserved, transmit_framing, transmit_framing_reserved}, {r[2], r[1:0], ^r[1:0]}, "framing");
    end
    wr(6'h12, 8'h00);
  endtask
  // Envelope polarity and the event raised on each change
  task automatic t_env();
    @(negedge clk_sys);
    envelope_input_pin = 1'b1;
    @(negedge clk_sys);
    chk(envelope_internal_n, 1'b0, "active high pin");
    wr(6'h11, 8'h37);
    chk(envelope_input_activity_event, 1'b0, "event too early");
    @(negedge clk_sys);
    chk(envelope_input_activity_event, 1'b1, "polarity event");
    chk(envelope_internal_n, 1'b1, "idle low-active pin");
    envelope_input_pin = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(envelope_internal_n, 1'b0, "active low pin");
    wr(6'h11, 8'h3f);
    @(negedge clk_sys);
    chk(envelope_input_activity_event, 1'b1, "polarity event back");
  endtask
  // Standalone presets, automatic presets in traffic, result bit order
  task automatic t_crc();
    logic [15:0] pv [4] = '{16'h0000, 16'h6363, 16'ha671, 16'hffff};
    for (int p = 0; p < 4; p++) begin
      wr(6'h11, 8'h28 | 8'(p));
      repeat (2) @(negedge clk_sys);
      chk(crc_preset_value, pv[p], "standalone preset");
    end
    wr(6'h11, 8'ha8);
    rf_active = 1'b1;
    crc_result_raw = 16'h0c31;
    repeat (2) @(negedge clk_sys);
    chk(crc_preset_value, 16'h6363, "auto preset A");
    chk(crc_result, 16'h0c31, "order kept in traffic");
    chk(crc_msb_first, 1'b0, "order off in traffic");
    receive_framing = 2'b11;
    repeat (2) @(negedge clk_sys);
    chk(crc_preset_value, 16'hffff, "auto preset B");
    tx_active = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk(crc_preset_value, 16'h6363, "auto preset tx A");
    wr(6'h12, 8'h03);
    repeat (2) @(negedge clk_sys);
    chk(crc_preset_value, 16'hffff, "auto preset tx B");
    {rf_active, tx_active} = 2'b00;
    repeat (2) @(negedge clk_sys);
    chk(crc_result, 16'h308c, "reversed bytes");
    chk(crc_msb_first, 1'b1, "order in standalone");
    wr(6'h11, 8'h3f);
    wr(6'h12, 8'h00);
  endtask
  // Main sequence
  initial begin
    errors = 0;
    tests_run = 0;
    rst_b = 1'b0;
    {reg_wr, reg_rd, rf_active, tx_active, rf_field_on, tx_start_req, envelope_input_pin} = '0;
    {reg_addr, reg_wdata, receive_framing, crc_result_raw} = '0;
    repeat (4) @(negedge clk_sys);
    rst_b = 1'b1;
    t_map();
    t_collision();
    t_tx();
    t_env();
    t_crc();
    report_and_stop();
  end
endmodule // rmc_regs_bench
`default_nettype wire
